// ### pwm_pkg.sv
/*
 * Shared constants for the PWM channel: register byte addresses, field
 * positions, reset values and counter limits.
 * Assumes a 32-bit classic Wishbone bus with one register per aligned word.
 */
`default_nettype none
package pwm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int CSS_W = 2;
    localparam int SEL_LANE0 = 0;

    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] MOD_HI_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] MOD_LO_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] CV_HI_ADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] CV_LO_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] ACTIVE_ADDR = 8'h18;

    localparam int CTRL_CSS_LSB = 0;
    localparam int CTRL_CENTER_BIT = 2;
    localparam int CTRL_ELSA_BIT = 3;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_DOWN_BIT = 16;
    localparam int STAT_PWM_BIT = 17;
    localparam int ACT_CV_LSB = 0;
    localparam int ACT_PEND_BIT = 16;
    localparam int HI_LSB = 8;

    localparam logic [CSS_W-1:0] CSS_STOPPED = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam int SIGN_BIT = 15;

    typedef enum logic {COUNT_UP, COUNT_DOWN} count_dir_t;
endpackage
`default_nettype wire

// ### byte_pair_buffer.sv
/*
 * Holding buffer for a 16-bit value written as two bytes in either order.
 * Assumes the write strobes are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_pair_buffer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_hi_i,
    input wire logic wr_lo_i,
    input wire logic [pwm_pkg::BYTE_W-1:0] byte_i,
    input wire logic clear_i,
    input wire logic absorb_i,
    output logic [pwm_pkg::CNT_W-1:0] value_o,
    output logic [pwm_pkg::CNT_W-1:0] next_value_o,
    output logic pair_done_o,
    output logic pending_o
);
    import pwm_pkg::*;
    logic [BYTE_W-1:0] hi;
    logic [BYTE_W-1:0] lo;
    logic hi_seen;
    logic lo_seen;

    assign value_o = {hi, lo};
    assign next_value_o = {wr_hi_i ? byte_i : hi, wr_lo_i ? byte_i : lo};
    assign pair_done_o = (wr_hi_i | wr_lo_i) & (wr_hi_i | hi_seen) & (wr_lo_i | lo_seen);
    assign pending_o = hi_seen & lo_seen;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi <= BYTE_ZERO;
            lo <= BYTE_ZERO;
        end else begin
            if (wr_hi_i) hi <= byte_i;
            if (wr_lo_i) lo <= byte_i;
        end
    end

    // A write not absorbed by this cycle's load survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i || absorb_i) begin
            hi_seen <= 1'b0;
            lo_seen <= 1'b0;
        end else begin
            hi_seen <= wr_hi_i | (hi_seen & ~clear_i);
            lo_seen <= wr_lo_i | (lo_seen & ~clear_i);
        end
    end
endmodule
`default_nettype wire

// ### pwm_counter.sv
/*
 * Timer counter: wraps at the modulus in edge-aligned mode, counts up
 * and down between zero and the modulus in center-aligned mode.
 * Assumes run_i is low while the counter clock source is stopped.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic center_i,
    input wire logic [pwm_pkg::CNT_W-1:0] modulus_i,
    output logic [pwm_pkg::CNT_W-1:0] count_o,
    output pwm_pkg::count_dir_t dir_o
);
    import pwm_pkg::*;
    logic [CNT_W-1:0] top;

    assign top = (modulus_i == CNT_ZERO) ? CNT_MAX : modulus_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= CNT_ZERO;
            dir_o <= COUNT_UP;
        end else if (run_i) begin
            if (center_i) begin
                if (dir_o == COUNT_UP) begin
                    if (modulus_i != CNT_ZERO && count_o >= modulus_i) begin
                        count_o <= count_o - CNT_ONE;
                        dir_o <= (count_o > CNT_ONE) ? COUNT_DOWN : COUNT_UP;
                    end else begin
                        count_o <= count_o + CNT_ONE;
                    end
                end else if (count_o <= CNT_ONE) begin
                    count_o <= CNT_ZERO;
                    dir_o <= COUNT_UP;
                end else begin
                    count_o <= count_o - CNT_ONE;
                end
            end else begin
                dir_o <= COUNT_UP;
                count_o <= (count_o >= top) ? CNT_ZERO : count_o + CNT_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// ### timer_pwm_channel_modes.sv
/*
 * One timer channel generating edge-aligned or center-aligned PWM, with
 * double-buffered 16-bit compare and modulus written a byte at a time.
 * Assumes a classic Wishbone master on clk_i and a load on pwm_o.
 */
// Contract
// - Edge mode, compare value zero gives 0% duty.
// - Edge mode, compare above modulus gives 100% duty.
// - Compare byte writes go to holding buffers, not active register.
// - Counter stopped: buffered compare loads when second byte written.
// - Counter running: load after both bytes, stepping modulus-1 to modulus.
// - Free-running counter: load stepping from 0xfffe to 0xffff.
// - Center select makes counter count up and down.
// - Center mode: pulse twice compare value, period twice modulus (code: compare equal to modulus gives twice compare minus one).
// - Edge/level select A sets output polarity.
// - Center mode: compare zero or sign bit set gives 0% duty.
// - Center mode: positive compare above modulus gives 100% duty.
// - Edge mode with zero modulus runs full 16-bit range, wraps.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_channel_modes (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pwm_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [pwm_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic [pwm_pkg::SEL_W-1:0] wb_sel_i,
    output logic [pwm_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic pwm_o
);
    import pwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Control state

    logic [CSS_W-1:0] counter_clock_source_select;
    logic center_aligned_select;
    logic edge_level_select_a;
    logic [CNT_W-1:0] active_cv;
    logic [CNT_W-1:0] modulus;
    logic [CNT_W-1:0] cnt;
    count_dir_t dir;

    logic req;
    logic wr_en;
    logic [BYTE_W-1:0] wr_byte;
    logic wr_ctrl;
    logic wr_mod_hi;
    logic wr_mod_lo;
    logic wr_cv_hi;
    logic wr_cv_lo;

    logic run;
    logic [CNT_W-1:0] top;
    logic step_to_top;
    logic load_now;
    logic load_at_top;
    logic load_cv;

    logic [CNT_W-1:0] cv_value;
    logic [CNT_W-1:0] cv_next;
    logic cv_done;
    logic cv_pending;
    logic [CNT_W-1:0] mod_value;
    logic [CNT_W-1:0] mod_next;
    logic mod_done;
    logic mod_pending;

    logic cv_negative;
    logic next_active;
    logic [DATA_W-1:0] next_rd;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, writes at the ack edge

    assign req = wb_cyc_i & wb_stb_i;
    assign wr_en = req & wb_ack_o & wb_we_i & wb_sel_i[SEL_LANE0];
    assign wr_byte = wb_dat_i[BYTE_W-1:0];
    assign wr_ctrl = wr_en && (wb_adr_i == CTRL_ADDR);
    assign wr_mod_hi = wr_en && (wb_adr_i == MOD_HI_ADDR);
    assign wr_mod_lo = wr_en && (wb_adr_i == MOD_LO_ADDR);
    assign wr_cv_hi = wr_en && (wb_adr_i == CV_HI_ADDR);
    assign wr_cv_lo = wr_en && (wb_adr_i == CV_LO_ADDR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // Unmapped addresses read as zero and still acknowledge
    always_comb begin
        next_rd = '0;
        case (wb_adr_i)
            CTRL_ADDR: begin
                next_rd[CTRL_CSS_LSB +: CSS_W] = counter_clock_source_select;
                next_rd[CTRL_CENTER_BIT] = center_aligned_select;
                next_rd[CTRL_ELSA_BIT] = edge_level_select_a;
            end
            MOD_HI_ADDR: next_rd[BYTE_W-1:0] = modulus[HI_LSB +: BYTE_W];
            MOD_LO_ADDR: next_rd[BYTE_W-1:0] = modulus[BYTE_W-1:0];
            CV_HI_ADDR: next_rd[BYTE_W-1:0] = cv_value[HI_LSB +: BYTE_W];
            CV_LO_ADDR: next_rd[BYTE_W-1:0] = cv_value[BYTE_W-1:0];
            STATUS_ADDR: begin
                next_rd[STAT_CNT_LSB +: CNT_W] = cnt;
                next_rd[STAT_DOWN_BIT] = (dir == COUNT_DOWN);
                next_rd[STAT_PWM_BIT] = pwm_o;
            end
            ACTIVE_ADDR: begin
                next_rd[ACT_CV_LSB +: CNT_W] = active_cv;
                next_rd[ACT_PEND_BIT] = cv_pending;
            end
            default: next_rd = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= next_rd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_clock_source_select <= CSS_STOPPED;
            center_aligned_select <= 1'b0;
            edge_level_select_a <= 1'b0;
        end else if (wr_ctrl) begin
            counter_clock_source_select <= wr_byte[CTRL_CSS_LSB +: CSS_W];
            center_aligned_select <= wr_byte[CTRL_CENTER_BIT];
            edge_level_select_a <= wr_byte[CTRL_ELSA_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte-pair buffers and compare load timing

    byte_pair_buffer cv_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_hi_i(wr_cv_hi),
        .wr_lo_i(wr_cv_lo),
        .byte_i(wr_byte),
        .clear_i(load_at_top),
        .absorb_i(load_now),
        .value_o(cv_value),
        .next_value_o(cv_next),
        .pair_done_o(cv_done),
        .pending_o(cv_pending)
    );

    // Modulus takes effect as soon as its pair is complete
    byte_pair_buffer mod_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_hi_i(wr_mod_hi),
        .wr_lo_i(wr_mod_lo),
        .byte_i(wr_byte),
        .clear_i(mod_done),
        .absorb_i(mod_done),
        .value_o(mod_value),
        .next_value_o(mod_next),
        .pair_done_o(mod_done),
        .pending_o(mod_pending)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulus <= CNT_ZERO;
        end else if (mod_done) begin
            modulus <= mod_next;
        end
    end

    assign run = (counter_clock_source_select != CSS_STOPPED);
    assign top = (modulus == CNT_ZERO) ? CNT_MAX : modulus;

    // load on the step into the modulus
    // free-running counter steps into all ones
    assign step_to_top = run && (dir == COUNT_UP) && (cnt == top - CNT_ONE);
    // stopped counter loads on the second byte
    assign load_now = !run && cv_done;
    assign load_at_top = step_to_top && cv_pending;
    assign load_cv = load_now | load_at_top;

    // A pair completed on the step itself waits for the next period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_cv <= CNT_ZERO;
        end else if (load_now) begin
            active_cv <= cv_next;
        end else if (load_at_top) begin
            active_cv <= cv_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and output

    pwm_counter counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .center_i(center_aligned_select),
        .modulus_i(modulus),
        .count_o(cnt),
        .dir_o(dir)
    );

    assign cv_negative = (active_cv == CNT_ZERO) || active_cv[SIGN_BIT];

    always_comb begin
        next_active = 1'b0;
        if (center_aligned_select) begin
            // high cv states going up and cv going down
            if (!cv_negative) begin
                next_active = (dir == COUNT_UP) ? (cnt < active_cv) : (cnt <= active_cv);
            end
        end else begin
            next_active = (cnt < active_cv);
        end
    end

    // select A set makes the output low-true
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= next_active ^ edge_level_select_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    zero_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!center_aligned_select && active_cv == CNT_ZERO)
        |=> pwm_o == $past(edge_level_select_a))
        else $error("edge mode zero compare drove the output active");

    // A count left above a newly shrunk modulus has not settled yet
    full_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!center_aligned_select && active_cv > top && cnt <= top)
        |=> pwm_o != $past(edge_level_select_a))
        else $error("edge mode compare above modulus left output inactive");

    buffer_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && (wr_cv_hi || wr_cv_lo) && !step_to_top)
        |=> $stable(active_cv))
        else $error("compare byte write reached the active compare value");

    stopped_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!run && cv_done)
        |=> active_cv == $past(cv_next))
        else $error("stopped counter did not load the completed pair");

    running_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && !step_to_top)
        |=> $stable(active_cv))
        else $error("running counter loaded compare off the modulus step");

    freerun_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && !center_aligned_select && modulus == CNT_ZERO
         && cnt == CNT_MAX - CNT_ONE && cv_pending)
        |=> (active_cv == $past(cv_value)) && (cnt == CNT_MAX))
        else $error("free-running counter missed the load at all ones");

    turn_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && center_aligned_select && modulus > CNT_ONE
         && cnt == modulus && dir == COUNT_UP)
        |=> (dir == COUNT_DOWN) && (cnt == $past(modulus) - CNT_ONE))
        else $error("center counter did not turn down at the modulus");

    turn_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && center_aligned_select && dir == COUNT_DOWN && cnt == CNT_ONE)
        |=> (dir == COUNT_UP) && (cnt == CNT_ZERO) ##1 (cnt == CNT_ONE || !run))
        else $error("center counter did not turn up at zero");

    center_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (center_aligned_select && cv_negative)
        |=> pwm_o == $past(edge_level_select_a))
        else $error("center mode zero or negative compare drove output");

    center_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (center_aligned_select && !cv_negative && modulus != CNT_ZERO
         && active_cv > modulus && cnt <= modulus)
        |=> pwm_o != $past(edge_level_select_a))
        else $error("center mode compare above modulus dropped output");

    freerun_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && !center_aligned_select && modulus == CNT_ZERO && cnt == CNT_MAX)
        |=> cnt == CNT_ZERO)
        else $error("free-running counter did not wrap to zero");

    rollover_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!center_aligned_select && cnt == CNT_ZERO && active_cv != CNT_ZERO)
        |=> pwm_o != $past(edge_level_select_a))
        else $error("edge mode output not active after rollover");

    polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(edge_level_select_a) && $stable(cnt) && $stable(active_cv)
        && $stable(dir) && $stable(center_aligned_select)
        |=> pwm_o != $past(pwm_o))
        else $error("polarity change did not invert the output");

    load_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !load_cv |=> $stable(active_cv))
        else $error("active compare changed without a load");

    match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!center_aligned_select && active_cv != CNT_ZERO && cnt == active_cv)
        |=> pwm_o == $past(edge_level_select_a))
        else $error("edge mode output still active after compare match");

    mod_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mod_done |=> (modulus == mod_value) && !mod_pending)
        else $error("completed modulus pair did not become active");

    edge_count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (run && !center_aligned_select) |=> dir == COUNT_UP)
        else $error("edge mode counter not counting up");
endmodule
`default_nettype wire

// ### pwm_load.sv
/*
 * Model of the load on the PWM pin: counts the clock edges at which the
 * pin is high, over a window that the bench opens with clear_i.
 * Assumes the pin is a registered level on the same clock as the timer.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pwm_i,
    input wire logic clear_i,
    output logic [31:0] high_count_o
);
    // A purely resistive load: it only integrates the high time
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            high_count_o <= 32'h0;
        end else if (pwm_i) begin
            high_count_o <= high_count_o + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
/*
 * Self-checking bench for the PWM channel: Wishbone register traffic,
 * compare-buffer loading and duty/period checks against an integer model.
 * Assumes the channel's register map and its one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    $display("mismatch %s expected %h seen %h", nm, e, g); fail_count++; end end
module tb;
    import pwm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pwm_o;
    logic clear = 1'b0;
    logic [31:0] high;
    logic [31:0] q;
    int fail_count = 0;
    int checked = 0;

    timer_pwm_channel_modes i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o));
    pwm_load i_load (.clk_i(clk_i), .rst_i(rst_i), .pwm_i(pwm_o), .clear_i(clear),
        .high_count_o(high));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One classic cycle; read data is taken at the edge that samples ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            stop_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] b);
        wb(1'b1, a, {24'h0, b}, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    // Byte order is random: the pair may arrive high-first or low-first
    task automatic set16(input logic [7:0] ha, input logic [7:0] la, input logic [15:0] v);
        if ($urandom % 2) begin
            wr8(ha, v[15:8]);
            wr8(la, v[7:0]);
        end else begin
            wr8(la, v[7:0]);
            wr8(ha, v[15:8]);
        end
    endtask

    // Bounded poll; a stuck counter ends the run
    task automatic wait_count(input logic [15:0] lim);
        int n;
        n = 0;
        do begin
            rd(STATUS_ADDR);
            n++;
        end while (q[15:0] < lim && n < 30000);
        if (q[15:0] < lim) begin
            fail_count++;
            stop_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Integer model: high cycles per period and the period itself
    function automatic int exp_high(input bit c, input bit el, input int md, input int cv,
                                    output int per);
        int act;
        if (!c) begin
            per = (md == 0) ? 65536 : md + 1;
            act = (cv == 0) ? 0 : (cv > md) ? per : cv;
        end else begin
            per = 2 * md;
            act = (cv == 0 || cv >= 32768) ? 0 : (cv > md) ? per : (cv == md) ? per - 1 : 2 * cv;
        end
        return el ? per - act : act;
    endfunction

    task automatic run_case(input bit c, input bit el, input int md, input int cv);
        int per;
        int e;
        int css;
        wr8(CTRL_ADDR, 8'h00);
        set16(MOD_HI_ADDR, MOD_LO_ADDR, md[15:0]);
        set16(CV_HI_ADDR, CV_LO_ADDR, cv[15:0]);
        rd(ACTIVE_ADDR);
        `CHK("active_stopped", {16'h0, cv[15:0]}, q)
        e = exp_high(c, el, md, cv, per);
        css = 1 + $urandom % 3;
        wr8(CTRL_ADDR, {4'h0, el, c, css[1:0]});
        repeat (2 * per + 64) @(posedge clk_i);
        clear <= 1'b1;
        @(posedge clk_i);
        clear <= 1'b0;
        repeat (3 * per) @(posedge clk_i);
        @(negedge clk_i);
        if (!c) `CHK("edge_high", 32'(3 * e), high)
        else `CHK("center_high", 32'(3 * e), high)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int md;
        void'($urandom(32'hbeb0de8e));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Free-running counter, modulus still zero from reset
        set16(CV_HI_ADDR, CV_LO_ADDR, 16'h0005);
        wr8(CTRL_ADDR, 8'h01);
        set16(CV_HI_ADDR, CV_LO_ADDR, 16'h1234);
        rd(ACTIVE_ADDR);
        `CHK("active_held", {15'h0, 1'b1, 16'h0005}, q)
        wait_count(16'hfff0);
        rd(ACTIVE_ADDR);
        `CHK("active_not_early", {15'h0, 1'b1, 16'h0005}, q)
        repeat (20) @(posedge clk_i);
        rd(STATUS_ADDR);
        `CHK("wrapped", 1'b1, q[15:0] < 16'h0020)
        rd(ACTIVE_ADDR);
        `CHK("active_free", {15'h0, 1'b0, 16'h1234}, q)
        // Running with a modulus: load waits for the step into the top
        set16(MOD_HI_ADDR, MOD_LO_ADDR, 16'd200);
        set16(CV_HI_ADDR, CV_LO_ADDR, 16'h0050);
        rd(ACTIVE_ADDR);
        `CHK("active_wait", {15'h0, 1'b1, 16'h1234}, q)
        wait_count(16'd190);
        rd(ACTIVE_ADDR);
        `CHK("active_wait2", {15'h0, 1'b1, 16'h1234}, q)
        repeat (20) @(posedge clk_i);
        rd(ACTIVE_ADDR);
        `CHK("active_mod", {15'h0, 1'b0, 16'h0050}, q)
        // Duty corners; modulus kept legal for each mode
        run_case(1'b0, 1'b0, 9, 0);
        run_case(1'b0, 1'b0, 9, 10);
        run_case(1'b0, 1'b1, 9, 4);
        run_case(1'b1, 1'b0, 6, 2);
        run_case(1'b1, 1'b0, 6, 32'h8003);
        run_case(1'b1, 1'b0, 6, 0);
        run_case(1'b1, 1'b1, 6, 7);
        repeat (12) begin
            md = 1 + $urandom % 40;
            run_case(1'b0, $urandom % 2, md, $urandom % (md + 2));
            md = 1 + $urandom % 30;
            run_case(1'b1, $urandom % 2, md, $urandom % (md + 3));
        end
        // Register corners: masked write, unmapped place
        wr8(CTRL_ADDR, 8'h00);
        set16(CV_HI_ADDR, CV_LO_ADDR, 16'h2a3c);
        wb(1'b1, CV_HI_ADDR, 32'h000000ab, 4'h0);
        rd(CV_HI_ADDR);
        `CHK("cv_hi_sel0", 32'h0000002a, q)
        wb(1'b1, 8'h1c, 32'h000000ff, 4'h1);
        rd(8'h1c);
        `CHK("unmapped", 32'h0, q)
        rd(CTRL_ADDR);
        `CHK("ctrl", 32'h0, q)
        stop_test();
    end
endmodule
`default_nettype wire
